// [rtl/ams_interval_timer.sv]
// background interval timer for one measurement channel
// assumes a one-cycle seconds tick from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module ams_interval_timer #(
    parameter int CNT_W  = 10,
    parameter int SEC_01 = 480,
    parameter int SEC_10 = 120,
    parameter int SEC_11 = 60
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       sec_tick,
    input  wire logic [1:0] period_code,
    input  wire logic       restart,
    output logic            due
);
    logic [CNT_W-1:0] count_reg;   // seconds elapsed in the interval
    logic [CNT_W-1:0] last_sec;    // final count of the interval

    // code to last count; code 00 disables the channel
    always_comb begin
        case (period_code)
            2'h1:    last_sec = CNT_W'(SEC_01 - 1);
            2'h2:    last_sec = CNT_W'(SEC_10 - 1);
            2'h3:    last_sec = CNT_W'(SEC_11 - 1);
            default: last_sec = '0;
        endcase
    end

    // seconds counter, cleared on restart or when disabled
    always_ff @(posedge mclk) begin
        if (sys_rst || restart || period_code == 2'h0) begin
            count_reg <= '0;
        end else if (sec_tick) begin
            count_reg <= (count_reg == last_sec) ? '0 : count_reg + 1'b1;
        end
    end

    // one-cycle strobe at the end of each interval
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            due <= 1'b0;
        end else begin
            due <= sec_tick && !restart && period_code != 2'h0 && count_reg == last_sec;
        end
    end
endmodule // ams_interval_timer
`default_nettype wire

// [rtl/ams_pkg.sv]
// shared constants and carrier types for the auxiliary converter scheduler
// assumes one 100 MHz system clock and an 8-bit special function register port
package ams_pkg;

    // special function register addresses
    localparam logic [7:0] TEMP_RESULT_ADDR = 8'hD7;
    localparam logic [7:0] START_CONV_ADDR  = 8'hD8;
    localparam logic [7:0] BATT_RESULT_ADDR = 8'hDF;
    localparam logic [7:0] SUP_RESULT_ADDR  = 8'hEF;
    localparam logic [7:0] DELTA_CFG_ADDR   = 8'hF3;
    localparam logic [7:0] STROBE_INT_ADDR  = 8'hF9;
    localparam logic [7:0] LOW_BATT_ADDR    = 8'hFA;

    // reset values
    localparam logic [7:0] REG_RESET        = 8'h00;

    // strobe interval field positions (low bit of each two-bit field)
    localparam int SUP_INT_LSB  = 4;
    localparam int BATT_INT_LSB = 2;
    localparam int TEMP_INT_LSB = 0;
    // delta field positions (low bit of each three-bit field)
    localparam int TEMP_DELTA_LSB = 3;
    localparam int SUP_DELTA_LSB  = 0;
    // delta codes
    localparam logic [2:0] DELTA_NEVER  = 3'h0;
    localparam logic [2:0] DELTA_ALWAYS = 3'h7;

    // channel numbers, also bit positions in start_conversion
    localparam logic [1:0] CH_BATT = 2'h0;
    localparam logic [1:0] CH_TEMP = 2'h1;
    localparam logic [1:0] CH_SUP  = 2'h2;

    // interval choices in minutes for codes 01, 10, 11
    localparam int SUP_MIN_01  = 8;
    localparam int SUP_MIN_10  = 2;
    localparam int SUP_MIN_11  = 1;
    localparam int BATT_MIN_01 = 16;
    localparam int BATT_MIN_10 = 4;
    localparam int BATT_MIN_11 = 1;
    localparam int TEMP_MIN_01 = 8;
    localparam int TEMP_MIN_10 = 2;
    localparam int TEMP_MIN_11 = 1;
    localparam int SEC_PER_MIN = 60;

    // one-second tick derived from the clock period
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1000000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // width of the per-channel seconds counter (up to 960 s)
    localparam int SEC_CNT_W = 10;

    // finished conversion from the converter
    typedef struct packed {
        logic       done;   // one-cycle completion pulse
        logic [1:0] chan;   // channel converted
        logic [7:0] data;   // 8-bit result
    } ams_conv_res_t;

    // conversion request towards the converter
    typedef struct packed {
        logic       valid;  // request pending
        logic [1:0] chan;   // channel wanted
    } ams_conv_req_t;

endpackage

// [rtl/ams_scheduler.sv]
// measurement scheduler and change detector for the auxiliary converter
// assumes the core's register port and the converter share the system clock
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - bits 5:4 set supply background interval
// - bits 3:2 set battery background interval
// - bits 1:0 set temperature background interval
// - temperature delta field gates result interrupts
// - supply delta field gates result interrupts
// - background measurements also run in low-power modes
// - single request bits clear when converter accepts
// - interrupt when battery result below threshold
// - result registers update only on interrupt or software write
// - single temperature conversion always interrupts
module ams_scheduler #(
    parameter int TICK_CYCLES = ams_pkg::TICK_CYCLES
) (
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    input  wire logic [7:0]             sfr_addr,
    input  wire logic [7:0]             sfr_wdata,
    input  wire logic                   sfr_wr,
    input  wire logic                   sfr_rd,
    output logic [7:0]                  sfr_rdata,
    output ams_pkg::ams_conv_req_t      conv_req,
    input  wire logic                   conv_ack,
    input  wire ams_pkg::ams_conv_res_t conv_res,
    output logic                        adc_irq
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // absolute difference of two results
    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // delta decision: 000 never, 111 always, else difference of at least code
    function automatic logic delta_hit(input logic [2:0] code, input logic [7:0] diff);
        if (code == ams_pkg::DELTA_NEVER) begin
            delta_hit = 1'b0;
        end else if (code == ams_pkg::DELTA_ALWAYS) begin
            delta_hit = 1'b1;
        end else begin
            delta_hit = diff >= {5'h00, code};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] strobe_interval_reg;         // background intervals
    logic [7:0] delta_threshold_config_reg;  // change thresholds
    logic [2:0] start_conversion_reg;        // single-shot requests
    logic [7:0] low_battery_threshold_reg;   // battery alarm level
    logic [7:0] temperature_result_reg;      // last reported temperature
    logic [7:0] battery_result_reg;          // last reported battery
    logic [7:0] supply_result_reg;           // last reported supply

    logic [2:0] bg_pend_reg;                 // background requests waiting
    logic       temp_single_reg;             // temperature in flight is single-shot
    logic [TICK_CYCLES > 1 ? $clog2(TICK_CYCLES) - 1 : 0 : 0] pre_reg; // second prescaler
    logic       sec_tick;                    // one-cycle seconds enable
    logic [2:0] due;                         // interval strobes per channel
    logic [2:0] restart;                     // interval field changed

    // write strobes per register
    logic wr_strobe;
    logic wr_start;
    logic wr_delta;
    logic wr_thresh;
    logic wr_temp;
    logic wr_batt;
    logic wr_sup;
    assign wr_strobe = sfr_wr && sfr_addr == ams_pkg::STROBE_INT_ADDR;
    assign wr_start  = sfr_wr && sfr_addr == ams_pkg::START_CONV_ADDR;
    assign wr_delta  = sfr_wr && sfr_addr == ams_pkg::DELTA_CFG_ADDR;
    assign wr_thresh = sfr_wr && sfr_addr == ams_pkg::LOW_BATT_ADDR;
    assign wr_temp   = sfr_wr && sfr_addr == ams_pkg::TEMP_RESULT_ADDR;
    assign wr_batt   = sfr_wr && sfr_addr == ams_pkg::BATT_RESULT_ADDR;
    assign wr_sup    = sfr_wr && sfr_addr == ams_pkg::SUP_RESULT_ADDR;

    // configuration registers; bits 7:6 of the interval register are
    // stored as written but steer nothing
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            strobe_interval_reg        <= ams_pkg::REG_RESET;
            delta_threshold_config_reg <= ams_pkg::REG_RESET;
            low_battery_threshold_reg  <= ams_pkg::REG_RESET;
        end else begin
            if (wr_strobe) begin
                strobe_interval_reg <= sfr_wdata;
            end
            if (wr_delta) begin
                delta_threshold_config_reg <= {2'h0, sfr_wdata[5:0]};
            end
            if (wr_thresh) begin
                low_battery_threshold_reg <= sfr_wdata;
            end
        end
    end

    // restart a channel's timer only when its field really changes
    always_comb begin
        restart[ams_pkg::CH_SUP] = wr_strobe &&
            sfr_wdata[ams_pkg::SUP_INT_LSB +: 2] !=
            strobe_interval_reg[ams_pkg::SUP_INT_LSB +: 2];
        restart[ams_pkg::CH_BATT] = wr_strobe &&
            sfr_wdata[ams_pkg::BATT_INT_LSB +: 2] !=
            strobe_interval_reg[ams_pkg::BATT_INT_LSB +: 2];
        restart[ams_pkg::CH_TEMP] = wr_strobe &&
            sfr_wdata[ams_pkg::TEMP_INT_LSB +: 2] !=
            strobe_interval_reg[ams_pkg::TEMP_INT_LSB +: 2];
    end

    ////////////////////////////////////////////////////////////////////////
    // timing

    // seconds prescaler; runs in every power mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pre_reg  <= '0;
            sec_tick <= 1'b0;
        end else if (pre_reg == $bits(pre_reg)'(TICK_CYCLES - 1)) begin
            pre_reg  <= '0;
            sec_tick <= 1'b1;
        end else begin
            pre_reg  <= pre_reg + 1'b1;
            sec_tick <= 1'b0;
        end
    end

    // supply interval 8, 2, 1 minutes
    ams_interval_timer #(
        .CNT_W  (ams_pkg::SEC_CNT_W),
        .SEC_01 (ams_pkg::SUP_MIN_01 * ams_pkg::SEC_PER_MIN),
        .SEC_10 (ams_pkg::SUP_MIN_10 * ams_pkg::SEC_PER_MIN),
        .SEC_11 (ams_pkg::SUP_MIN_11 * ams_pkg::SEC_PER_MIN)
    ) u_sup_timer (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .sec_tick    (sec_tick),
        .period_code (strobe_interval_reg[ams_pkg::SUP_INT_LSB +: 2]),
        .restart     (restart[ams_pkg::CH_SUP]),
        .due         (due[ams_pkg::CH_SUP])
    );

    // battery interval 16, 4, 1 minutes
    ams_interval_timer #(
        .CNT_W  (ams_pkg::SEC_CNT_W),
        .SEC_01 (ams_pkg::BATT_MIN_01 * ams_pkg::SEC_PER_MIN),
        .SEC_10 (ams_pkg::BATT_MIN_10 * ams_pkg::SEC_PER_MIN),
        .SEC_11 (ams_pkg::BATT_MIN_11 * ams_pkg::SEC_PER_MIN)
    ) u_batt_timer (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .sec_tick    (sec_tick),
        .period_code (strobe_interval_reg[ams_pkg::BATT_INT_LSB +: 2]),
        .restart     (restart[ams_pkg::CH_BATT]),
        .due         (due[ams_pkg::CH_BATT])
    );

    // temperature interval 8, 2, 1 minutes
    ams_interval_timer #(
        .CNT_W  (ams_pkg::SEC_CNT_W),
        .SEC_01 (ams_pkg::TEMP_MIN_01 * ams_pkg::SEC_PER_MIN),
        .SEC_10 (ams_pkg::TEMP_MIN_10 * ams_pkg::SEC_PER_MIN),
        .SEC_11 (ams_pkg::TEMP_MIN_11 * ams_pkg::SEC_PER_MIN)
    ) u_temp_timer (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .sec_tick    (sec_tick),
        .period_code (strobe_interval_reg[ams_pkg::TEMP_INT_LSB +: 2]),
        .restart     (restart[ams_pkg::CH_TEMP]),
        .due         (due[ams_pkg::CH_TEMP])
    );

    ////////////////////////////////////////////////////////////////////////
    // request arbitration

    logic [2:0] want;      // channels wanting a conversion
    logic [2:0] granted;   // one-hot accepted channel this cycle
    assign want = bg_pend_reg | start_conversion_reg;

    // fixed priority: battery, temperature, supply
    always_comb begin
        conv_req.valid = |want;
        if (want[ams_pkg::CH_BATT]) begin
            conv_req.chan = ams_pkg::CH_BATT;
        end else if (want[ams_pkg::CH_TEMP]) begin
            conv_req.chan = ams_pkg::CH_TEMP;
        end else begin
            conv_req.chan = ams_pkg::CH_SUP;
        end
        granted = (conv_req.valid && conv_ack) ? 3'h1 << conv_req.chan : 3'h0;
    end

    // single-shot bits: software sets, acceptance clears, a set wins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            start_conversion_reg <= 3'h0;
        end else begin
            start_conversion_reg <= (start_conversion_reg & ~granted) |
                                    (wr_start ? sfr_wdata[2:0] : 3'h0);
        end
    end

    // background requests: interval strobe sets, acceptance clears
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bg_pend_reg <= 3'h0;
        end else begin
            bg_pend_reg <= (bg_pend_reg & ~granted) | due;
        end
    end

    // remember whether the accepted temperature conversion was single-shot
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            temp_single_reg <= 1'b0;
        end else if (granted[ams_pkg::CH_TEMP]) begin
            temp_single_reg <= start_conversion_reg[ams_pkg::CH_TEMP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result judgement

    logic temp_hit;   // temperature result reports
    logic batt_hit;   // battery result reports
    logic sup_hit;    // supply result reports
    always_comb begin
        temp_hit = conv_res.done && conv_res.chan == ams_pkg::CH_TEMP &&
            (delta_hit(delta_threshold_config_reg[ams_pkg::TEMP_DELTA_LSB +: 3],
                       abs_diff(conv_res.data, temperature_result_reg))
             || temp_single_reg);
        sup_hit = conv_res.done && conv_res.chan == ams_pkg::CH_SUP &&
            delta_hit(delta_threshold_config_reg[ams_pkg::SUP_DELTA_LSB +: 3],
                      abs_diff(conv_res.data, supply_result_reg));
        batt_hit = conv_res.done && conv_res.chan == ams_pkg::CH_BATT &&
            conv_res.data < low_battery_threshold_reg;
    end

    // results change only with an interrupt; software may also write them
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            temperature_result_reg <= ams_pkg::REG_RESET;
            battery_result_reg     <= ams_pkg::REG_RESET;
            supply_result_reg      <= ams_pkg::REG_RESET;
        end else begin
            if (temp_hit) begin
                temperature_result_reg <= conv_res.data;
            end else if (wr_temp) begin
                temperature_result_reg <= sfr_wdata;
            end
            if (batt_hit) begin
                battery_result_reg <= conv_res.data;
            end else if (wr_batt) begin
                battery_result_reg <= sfr_wdata;
            end
            if (sup_hit) begin
                supply_result_reg <= conv_res.data;
            end else if (wr_sup) begin
                supply_result_reg <= sfr_wdata;
            end
        end
    end

    // converter interrupt pulse, no status flag
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            adc_irq <= 1'b0;
        end else begin
            adc_irq <= temp_hit || batt_hit || sup_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port, one cycle after the read strobe

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                ams_pkg::STROBE_INT_ADDR:  sfr_rdata <= strobe_interval_reg;
                ams_pkg::DELTA_CFG_ADDR:   sfr_rdata <= delta_threshold_config_reg;
                ams_pkg::START_CONV_ADDR:  sfr_rdata <= {5'h00, start_conversion_reg};
                ams_pkg::LOW_BATT_ADDR:    sfr_rdata <= low_battery_threshold_reg;
                ams_pkg::TEMP_RESULT_ADDR: sfr_rdata <= temperature_result_reg;
                ams_pkg::BATT_RESULT_ADDR: sfr_rdata <= battery_result_reg;
                ams_pkg::SUP_RESULT_ADDR:  sfr_rdata <= supply_result_reg;
                default:                   sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule // ams_scheduler
`default_nettype wire

// [test/ams_conv_model.sv]
// behavioural converter facing the scheduler request port
// assumes the scheduler clock and reset
`timescale 1ns/10ps
`default_nettype none
module ams_conv_model (
    input wire logic                   mclk,
    input wire logic                   sys_rst,
    input wire ams_pkg::ams_conv_req_t conv_req,
    output var logic                   conv_ack,
    output var ams_pkg::ams_conv_res_t conv_res,
    input wire logic [7:0]             mdata,
    input wire logic                   slow
);
    int         wait_cnt; // cycles in the current phase
    logic       busy;     // converting a taken request
    logic [1:0] chan;     // channel taken
    ////////////////////////////////////////
    // accept promptly or late, answer four cycles after the take
    always @(posedge mclk) begin
        conv_ack <= 1'b0;
        conv_res.done <= 1'b0;
        conv_res.data <= ~conv_res.data; // idle data never looks valid
        if (sys_rst) begin
            conv_res <= '0;
            busy <= 1'b0;
            wait_cnt <= 0;
        end else if (busy) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == 3) begin
                conv_res <= {1'b1, chan, mdata};
                busy <= 1'b0;
                wait_cnt <= 0;
            end
        end else if (conv_req.valid && !conv_ack) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt >= (slow ? 5 : 0)) begin
                conv_ack <= 1'b1;
                chan <= conv_req.chan;
                busy <= 1'b1;
                wait_cnt <= 0;
            end
        end
    end
endmodule // ams_conv_model
`default_nettype wire

// [test/ams_scheduler_sva.sv]
// port checker for the converter scheduler
// assumes one clock domain and a bind onto ams_scheduler
`timescale 1ns/10ps
`default_nettype none
module ams_scheduler_sva (
    input wire logic                   mclk,
    input wire logic                   sys_rst,
    input wire logic [7:0]             sfr_addr,
    input wire logic [7:0]             sfr_wdata,
    input wire logic                   sfr_wr,
    input wire logic                   sfr_rd,
    input wire logic [7:0]             sfr_rdata,
    input wire ams_pkg::ams_conv_req_t conv_req,
    input wire logic                   conv_ack,
    input wire ams_pkg::ams_conv_res_t conv_res,
    input wire logic                   adc_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [7:0] dcfg_reg; // delta setting as written
    logic [7:0] strb_reg; // strobe setting as written
    logic [7:0] thr_reg;  // battery threshold as written
    ////////////////////////////////////////
    // shadow copies of software writes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dcfg_reg <= 8'h00;
            strb_reg <= 8'h00;
            thr_reg  <= 8'h00;
        end else if (sfr_wr) begin
            if (sfr_addr == ams_pkg::DELTA_CFG_ADDR) dcfg_reg <= {2'h0, sfr_wdata[5:0]};
            if (sfr_addr == ams_pkg::STROBE_INT_ADDR) strb_reg <= sfr_wdata;
            if (sfr_addr == ams_pkg::LOW_BATT_ADDR) thr_reg <= sfr_wdata;
        end
    end
    ////////////////////////////////////////
    property p_irq_cause; adc_irq |-> $past(conv_res.done); endproperty
    property p_sup_never; conv_res.done && conv_res.chan == ams_pkg::CH_SUP
        && dcfg_reg[2:0] == 3'h0 |=> !adc_irq; endproperty
    property p_sup_always; conv_res.done && conv_res.chan == ams_pkg::CH_SUP
        && dcfg_reg[2:0] == 3'h7 |=> adc_irq; endproperty
    property p_temp_always; conv_res.done && conv_res.chan == ams_pkg::CH_TEMP
        && dcfg_reg[5:3] == 3'h7 |=> adc_irq; endproperty
    property p_batt_low; conv_res.done && conv_res.chan == ams_pkg::CH_BATT
        && conv_res.data < thr_reg |=> adc_irq; endproperty
    property p_batt_high; conv_res.done && conv_res.chan == ams_pkg::CH_BATT
        && conv_res.data >= thr_reg |=> !adc_irq; endproperty
    property p_req_hold; conv_req.valid && !conv_ack |=> conv_req.valid; endproperty
    property p_rd_strobe; sfr_rd && sfr_addr == ams_pkg::STROBE_INT_ADDR
        |=> sfr_rdata == $past(strb_reg); endproperty
    property p_rd_delta; sfr_rd && sfr_addr == ams_pkg::DELTA_CFG_ADDR
        |=> sfr_rdata == $past(dcfg_reg); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without result");
    a_sup_never: assert property (p_sup_never) else $error("supply irq at code 0");
    a_sup_always: assert property (p_sup_always) else $error("supply irq missing");
    a_temp_always: assert property (p_temp_always) else $error("temp irq missing");
    a_batt_low: assert property (p_batt_low) else $error("low battery irq missing");
    a_batt_high: assert property (p_batt_high) else $error("battery irq unexpected");
    a_req_hold: assert property (p_req_hold) else $error("request dropped unaccepted");
    a_rd_strobe: assert property (p_rd_strobe) else $error("strobe read wrong");
    a_rd_delta: assert property (p_rd_delta) else $error("delta read wrong");
    c_irq: cover property (adc_irq);
    c_ack: cover property (conv_req.valid && conv_ack);
    c_low: cover property (conv_res.done && conv_res.chan == ams_pkg::CH_BATT
        && conv_res.data < thr_reg ##1 adc_irq);
endmodule // ams_scheduler_sva
bind ams_scheduler ams_scheduler_sva u_sva (.mclk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_rdata, .conv_req, .conv_ack, .conv_res, .adc_irq);
`default_nettype wire

// [test/ams_scheduler_tb.sv]
// self-checking bench for the converter scheduler
// assumes the converter model and checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module ams_scheduler_tb;
    localparam int TK = 4; // cycles per shortened second
    logic                   mclk;
    logic                   sys_rst;
    logic [7:0]             sfr_addr;
    logic [7:0]             sfr_wdata;
    logic                   sfr_wr;
    logic                   sfr_rd;
    logic [7:0]             sfr_rdata;
    ams_pkg::ams_conv_req_t conv_req;
    logic                   conv_ack;
    ams_pkg::ams_conv_res_t conv_res;
    logic                   adc_irq;
    logic [7:0]             mdata; // value the converter returns
    logic                   slow;  // converter accepts late
    logic [7:0]             dcfg;  // delta setting in use
    logic [7:0]             thr;   // battery threshold in use
    logic [31:0]            seed;  // xorshift state
    int                     error_cnt;
    int                     checked;
    ams_scheduler #(.TICK_CYCLES(TK)) dut (.mclk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr,
        .sfr_rd, .sfr_rdata, .conv_req, .conv_ack, .conv_res, .adc_irq);
    ams_conv_model u_conv (.mclk, .sys_rst, .conv_req, .conv_ack, .conv_res, .mdata, .slow);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // result register and strobe field of a channel
    function logic [7:0] raddr(input logic [1:0] ch);
        return ch == 2'h0 ? ams_pkg::BATT_RESULT_ADDR :
               ch == 2'h1 ? ams_pkg::TEMP_RESULT_ADDR : ams_pkg::SUP_RESULT_ADDR;
    endfunction
    function int flsb(input logic [1:0] ch);
        return ch == 2'h0 ? 2 : ch == 2'h1 ? 0 : 4;
    endfunction
    // interval in minutes: battery 16/4/1, others 8/2/1
    function int mins(input logic [1:0] ch, input logic [1:0] c);
        if (ch == 2'h0) return c == 2'h1 ? 16 : c == 2'h2 ? 4 : 1;
        return c == 2'h1 ? 8 : c == 2'h2 ? 2 : 1;
    endfunction
    // whether a result must be reported
    function logic exp_rep(input logic [1:0] ch, input logic [7:0] d, old, input logic one);
        logic [2:0] c;
        logic [7:0] df;
        c  = ch == 2'h1 ? dcfg[5:3] : dcfg[2:0];
        df = d > old ? d - old : old - d;
        if (ch == 2'h0) return d < thr;
        if (ch == 2'h1 && one) return 1'b1;
        if (c == 3'h0 || c == 3'h7) return c == 3'h7;
        return df >= {5'h0, c};
    endfunction
    ////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_wr    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        sfr_rd   <= 1'b1;
        sfr_addr <= a;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask
    // one measurement, single request at code 0, else background interval
    task automatic take(input logic [1:0] ch, input logic [1:0] code, input logic bnd);
        logic [7:0]  old;
        logic [7:0]  got;
        logic [31:0] r;
        logic        e;
        int          n;
        int          t;
        rd(raddr(ch), old);
        r = rnd();
        mdata = ch == 2'h0 ? thr : old + {5'h0, ch == 2'h1 ? dcfg[5:3] : dcfg[2:0]};
        mdata = bnd ? mdata - {7'h0, r[8]} : r[7:0];
        e = exp_rep(ch, mdata, old, code == 2'h0);
        t = code == 2'h0 ? 0 : mins(ch, code) * 60 * TK;
        if (code == 2'h0) wr(ams_pkg::START_CONV_ADDR, 8'h01 << ch);
        else begin
            // start on another code, then change it: timing must run from the change
            wr(ams_pkg::STROBE_INT_ADDR, {6'h0, 2'(code % 3 + 1)} << flsb(ch));
            repeat (40) @(posedge mclk);
            wr(ams_pkg::STROBE_INT_ADDR, {6'h0, code} << flsb(ch));
        end
        n = 0;
        while (conv_res.done !== 1'b1 && n < t + 40) begin
            @(posedge mclk);
            #1 n++;
        end
        `CHK(n >= t && n <= t + 20, 1'b1)
        @(posedge mclk);
        #1 `CHK(adc_irq, e)
        rd(raddr(ch), got);
        `CHK(got, e ? mdata : old)
        rd(ams_pkg::START_CONV_ADDR, got);
        `CHK(got, 8'h00)
        if (code != 2'h0) wr(ams_pkg::STROBE_INT_ADDR, 8'h00);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    // main sequence: register checks, single shots, background intervals
    initial begin
        logic [7:0]  got;
        logic [31:0] r;
        seed = 32'd6127;
        error_cnt = 0;
        checked = 0;
        sys_rst = 1'b1;
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, mdata, slow, dcfg} = '0;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(ams_pkg::STROBE_INT_ADDR, got);
        `CHK(got, 8'h00)
        rd(ams_pkg::DELTA_CFG_ADDR, got);
        `CHK(got, 8'h00)
        rd(8'hD9, got);
        `CHK(got, 8'h00)
        wr(ams_pkg::DELTA_CFG_ADDR, 8'hFF);
        rd(ams_pkg::DELTA_CFG_ADDR, got);
        `CHK(got, 8'h3F)
        r = rnd();
        thr = r[7:0];
        wr(ams_pkg::LOW_BATT_ADDR, thr);
        wr(ams_pkg::TEMP_RESULT_ADDR, r[15:8]);
        rd(ams_pkg::TEMP_RESULT_ADDR, got);
        `CHK(got, r[15:8])
        for (int c = 0; c < 8; c++) begin
            dcfg = {2'h0, c[2:0], c[2:0]};
            wr(ams_pkg::DELTA_CFG_ADDR, dcfg);
            for (int ch = 0; ch < 3; ch++) begin
                slow = ch[0];
                take(ch[1:0], 2'h0, c[0]);
            end
        end
        for (int i = 0; i < 9; i++) begin
            r = rnd();
            dcfg = {2'h0, r[5:0]};
            slow = r[6];
            wr(ams_pkg::DELTA_CFG_ADDR, dcfg);
            take(2'(i % 3), 2'(i / 3 + 1), r[7]);
        end
        results();
    end
    // watchdog well past the longest expected run
    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        results();
    end
endmodule // ams_scheduler_tb
`default_nettype wire
